/* twim_master.sv */
// twi master with segment commands behind an apb slave
`timescale 1ns/100ps
`include "twim_map.svh"
module twim_master import twim_pkg::*; (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // serial pins, open drain
  input wire logic scl_i,
  input wire logic sda_i,
  output logic scl_o,
  output logic sda_o,
  output logic scl_oe,
  output logic sda_oe
);
  logic [7:0] data_r; // shared tx and rx byte
  logic [2:0] mode_r; // function select
  logic [3:0] rlin_r; // linear divider
  logic [3:0] rexp_r; // exponent divider
  logic [3:0] cmd_r; // segment command bits
  logic ack_r; // ack after receive control
  logic [3:0] stat_r; // cmdfin rxfin txfin nack
  twim_state_t st_r;
  logic [1:0] ph_r; // quarter phase of bit
  logic [3:0] bit_r; // bit counter
  logic rx_r; // receiving direction
  logic [7:0] sh_r; // shift register
  logic [15:0] acc_r; // reference tick accumulator
  logic [19:0] div_r; // quarter period counter
  twim_pins_t pin_r;
  logic done_cmd, done_tx, done_rx, nack_seen, tick, go;
  logic wr_en;
  // apb strobe at access phase, zero wait state
  assign wr_en = psel && penable && pwrite;

  // quarter period in reference ticks: (lin+1)*2^exp/4, at least one
  function automatic logic [19:0] quarter(input logic [3:0] l,
                                          input logic [3:0] e);
    logic [19:0] p;
    p = 20'(({16'h0, l} + 20'h1) << e);
    quarter = (p > 20'h3) ? (p >> 2) : 20'h1;
  endfunction

  // reference tick generator at 12 mhz from clk
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      acc_r <= 16'h0;
    end else begin
      acc_r <= {8'h0, acc_r[7:0]} + 16'(`TWIM_STEP_X256);
    end
  end
  // carry out of the accumulator marks one reference tick
  logic ref_tick;
  assign ref_tick = acc_r[8];
  // a released clock that a slave still holds low pauses the bit
  logic stall;
  assign stall = !pin_r.scl_oe && !scl_i && ph_r != 2'h0 &&
                 st_r != ST_IDLE;

  // quarter period divider; stalls while slave stretches clock
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      div_r <= 20'h0;
    end else if (st_r == ST_IDLE) begin
      div_r <= 20'h0;
    end else if (stall) begin
      div_r <= div_r;
    end else if (ref_tick) begin
      div_r <= (div_r + 20'h1 >= quarter(rlin_r, rexp_r)) ? 20'h0 :
               div_r + 20'h1;
    end
  end
  // one tick per quarter bit, none while the clock is stretched
  assign tick = ref_tick && !stall &&
                (div_r + 20'h1 >= quarter(rlin_r, rexp_r));
  // segments start only with the two-wire function selected
  assign go = (mode_r == `TWIM_MODE_TWI);

  // segment sequencer
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      st_r <= ST_IDLE;
      ph_r <= 2'h0;
      bit_r <= 4'h0;
      rx_r <= 1'b0;
      sh_r <= 8'h0;
      pin_r <= '0;
    end else begin
      unique case (st_r)
        ST_IDLE: begin
          ph_r <= 2'h0;
          bit_r <= 4'h0;
          if (go && cmd_r[`TWIM_BIT_START]) begin
            st_r <= ST_START;
          end else if (go && cmd_r[`TWIM_BIT_SEND]) begin
            st_r <= ST_BIT;
            rx_r <= 1'b0;
            sh_r <= data_r;
          end else if (go && cmd_r[`TWIM_BIT_RECV]) begin
            st_r <= ST_BIT;
            rx_r <= 1'b1;
          end else if (go && cmd_r[`TWIM_BIT_STOP]) begin
            st_r <= ST_STOP;
          end
          // nothing pending keeps lines as they are
        end
        ST_START: if (tick) begin
          // release sda, raise scl, then pull sda, then scl low
          ph_r <= ph_r + 2'h1;
          unique case (ph_r)
            2'h0: pin_r.sda_oe <= 1'b0;
            2'h1: pin_r.scl_oe <= 1'b0;
            2'h2: pin_r.sda_oe <= 1'b1;
            default: begin
              pin_r.scl_oe <= 1'b1;
              st_r <= ST_IDLE;
            end
          endcase
        end
        ST_BIT, ST_ACK: if (tick) begin
          ph_r <= ph_r + 2'h1;
          unique case (ph_r)
            2'h0: begin
              // drive data while clock low
              if (st_r == ST_BIT) begin
                pin_r.sda_oe <= rx_r ? 1'b0 : !sh_r[7];
              end else begin
                pin_r.sda_oe <= rx_r ? ack_r : 1'b0;
              end
            end
            2'h1: pin_r.scl_oe <= 1'b0;
            2'h2: begin
              // sample real line level at clock high
              if (st_r == ST_BIT) begin
                sh_r <= {sh_r[6:0], sda_i};
              end
            end
            default: begin
              pin_r.scl_oe <= 1'b1;
              if (st_r == ST_ACK) begin
                st_r <= ST_IDLE;
              end else if (bit_r == 4'h7) begin
                st_r <= ST_ACK;
              end else begin
                bit_r <= bit_r + 4'h1;
              end
            end
          endcase
        end
        ST_STOP: if (tick) begin
          ph_r <= ph_r + 2'h1;
          unique case (ph_r)
            2'h0: pin_r.sda_oe <= 1'b1;
            2'h1: pin_r.scl_oe <= 1'b0;
            2'h2: pin_r.sda_oe <= 1'b0;
            default: st_r <= ST_IDLE;
          endcase
        end
        default: st_r <= ST_IDLE;
      endcase
    end
  end

  // segment completion pulses
  assign done_cmd = tick && ph_r == 2'h3 &&
                    (st_r == ST_START || st_r == ST_STOP);
  assign done_tx = tick && ph_r == 2'h3 && st_r == ST_ACK && !rx_r;
  assign done_rx = tick && ph_r == 2'h3 && st_r == ST_ACK && rx_r;
  logic ack_smp_r; // ninth bit level sampled at clock high
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      ack_smp_r <= 1'b0;
    end else if (st_r == ST_ACK && tick && ph_r == 2'h2) begin
      ack_smp_r <= sda_i;
    end
  end
  // a released ninth bit after a send is a nack
  assign nack_seen = done_tx && ack_smp_r;
  logic seg_start;
  // any accepted command counts as new bus activity
  assign seg_start = st_r == ST_IDLE && go && cmd_r != 4'h0;

  // command bits: software sets, hardware clears on completion
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cmd_r <= 4'h0;
    end else if (wr_en && paddr == `TWIM_OFS_CMD) begin
      cmd_r <= pwdata[3:0];
    end else if (done_cmd || done_tx || done_rx) begin
      cmd_r <= 4'h0;
    end
  end

  // status flags, cleared when the next segment begins
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      stat_r <= 4'h0;
    end else if (seg_start) begin
      stat_r <= 4'h0;
    end else begin
      if (done_cmd) stat_r[3] <= 1'b1;
      if (done_rx) stat_r[2] <= 1'b1;
      if (done_tx) stat_r[1] <= 1'b1;
      if (nack_seen) stat_r[0] <= 1'b1;
    end
  end

  // shared data register: software write or received byte
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      data_r <= 8'h0;
    end else if (done_rx) begin
      data_r <= sh_r;
    end else if (wr_en && paddr == `TWIM_OFS_DATA) begin
      data_r <= pwdata[7:0];
    end
  end

  // configuration registers
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      mode_r <= 3'h0;
      rlin_r <= 4'h0;
      rexp_r <= 4'h0;
      ack_r <= 1'b0;
    end else if (wr_en) begin
      if (paddr == `TWIM_OFS_MODE) mode_r <= pwdata[2:0];
      if (paddr == `TWIM_OFS_RLIN) rlin_r <= pwdata[3:0];
      if (paddr == `TWIM_OFS_REXP) rexp_r <= pwdata[3:0];
      if (paddr == `TWIM_OFS_ACK) ack_r <= pwdata[0];
    end
  end

  // apb read data, registered at setup phase; unmapped reads zero
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      prdata <= 32'h0;
      pready <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready <= psel && !penable;
      pslverr <= 1'b0;
      if (psel && !penable) begin
        unique case (paddr)
          `TWIM_OFS_DATA: prdata <= {24'h0, data_r};
          `TWIM_OFS_MODE: prdata <= {29'h0, mode_r};
          `TWIM_OFS_RLIN: prdata <= {28'h0, rlin_r};
          `TWIM_OFS_REXP: prdata <= {28'h0, rexp_r};
          `TWIM_OFS_STAT: prdata <= {28'h0, stat_r};
          `TWIM_OFS_CMD: prdata <= {28'h0, cmd_r};
          `TWIM_OFS_ACK: prdata <= {31'h0, ack_r};
          default: prdata <= 32'h0;
        endcase
      end
    end
  end

  // open drain: output always low, enable pulls the line
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      scl_o <= 1'b0;
      sda_o <= 1'b0;
      scl_oe <= 1'b0;
      sda_oe <= 1'b0;
    end else begin
      scl_o <= 1'b0;
      sda_o <= 1'b0;
      scl_oe <= pin_r.scl_oe;
      sda_oe <= pin_r.sda_oe;
    end
  end

  // assertions on the sequencer, the lines and the status side
  a_cmd_clear: assert property (@(posedge clk) disable iff (rst)
    done_tx |=> stat_r[1] && cmd_r == 4'h0)
    else $error("send bit not cleared on finish");
  a_stretch_hold: assert property (@(posedge clk) disable iff (rst)
    (!pin_r.scl_oe && !scl_i && ph_r != 2'h0 && st_r != ST_IDLE)
    |=> $stable(ph_r))
    else $error("phase advanced while clock stretched");
  a_stretch_pins: assert property (@(posedge clk) disable iff (rst)
    (!pin_r.scl_oe && !scl_i && ph_r != 2'h0)
    |=> $stable(pin_r) && $stable(div_r))
    else $error("lines or divider moved while clock stretched");
  a_idle_stay: assert property (@(posedge clk) disable iff (rst)
    (st_r == ST_IDLE && cmd_r == 4'h0) |=> st_r == ST_IDLE)
    else $error("left idle with no command");
  a_start_edge: assert property (@(posedge clk) disable iff (rst)
    (st_r == ST_START && tick && ph_r == 2'h2)
    |=> pin_r.sda_oe && !pin_r.scl_oe)
    else $error("start not made with clock high");
  a_msb_first: assert property (@(posedge clk) disable iff (rst)
    (st_r == ST_BIT && !rx_r && tick && ph_r == 2'h0)
    |=> pin_r.sda_oe == !$past(sh_r[7]))
    else $error("transmit bit not taken from the top");
  a_rx_released: assert property (@(posedge clk) disable iff (rst)
    (st_r == ST_BIT && rx_r && tick && ph_r == 2'h0)
    |=> !pin_r.sda_oe)
    else $error("data line pulled during receive");
  a_ack_drive: assert property (@(posedge clk) disable iff (rst)
    (st_r == ST_ACK && rx_r && tick && ph_r == 2'h0)
    |=> pin_r.sda_oe == $past(ack_r))
    else $error("ack bit does not follow control");
  a_rx_data: assert property (@(posedge clk) disable iff (rst)
    done_rx |=> data_r == $past(sh_r) && stat_r[2])
    else $error("received byte not stored");
  a_rx_clear: assert property (@(posedge clk) disable iff (rst)
    done_rx |=> cmd_r == 4'h0 && st_r == ST_IDLE)
    else $error("receive bit not cleared on finish");
  a_nack_flag: assert property (@(posedge clk) disable iff (rst)
    nack_seen |=> stat_r[0])
    else $error("nack not flagged");
  a_ack_flag: assert property (@(posedge clk) disable iff (rst)
    (done_tx && !ack_smp_r) |=> !stat_r[0])
    else $error("ack reported as nack");
  a_flag_clear: assert property (@(posedge clk) disable iff (rst)
    seg_start |=> stat_r == 4'h0)
    else $error("flags not cleared at activity");
  a_cmd_done: assert property (@(posedge clk) disable iff (rst)
    done_cmd |=> stat_r[3] && st_r == ST_IDLE)
    else $error("start or stop did not finish");
  a_mode_gate: assert property (@(posedge clk) disable iff (rst)
    (st_r == ST_IDLE && !go) |=> st_r == ST_IDLE)
    else $error("segment ran outside twi mode");
  a_stop_level: assert property (@(posedge clk) disable iff (rst)
    (st_r == ST_STOP && tick && ph_r == 2'h2) |=> !pin_r.sda_oe
    && !pin_r.scl_oe)
    else $error("stop not released with clock high");
  // covers of the main segment kinds and of a stretched clock
  c_start: cover property (@(posedge clk) disable iff (rst) done_cmd);
  c_send: cover property (@(posedge clk) disable iff (rst) done_tx);
  c_recv: cover property (@(posedge clk) disable iff (rst) done_rx);
  c_nack: cover property (@(posedge clk) disable iff (rst) nack_seen);
  c_stretch: cover property (@(posedge clk) disable iff (rst) stall);
endmodule

/* twim_map.svh */
// register offsets, field positions and timing counts for the twi master
// Contract
// - pause while slave holds clock low
// - start alone makes start or repeated start
// - send shifts byte msb first, ack ninth
// - receive clocks byte, drives ack ninth
// - stop releases data while clock high
// - no command bits means bus idle
// - ack control selects ack or nack
// - one shared data register both ways
// - start stop clear bit, set cmd flag
// - send clears bit, sets tx flag
// - receive clears bit, sets rx flag
// - status shows nack or ack
// - mode three enables master only
// - clock is 12 MHz over divider
// - status flags clear on next activity
`ifndef TWIM_MAP_SVH
`define TWIM_MAP_SVH
`define TWIM_OFS_DATA 12'h000
`define TWIM_OFS_MODE 12'h004
`define TWIM_OFS_RLIN 12'h008
`define TWIM_OFS_REXP 12'h00c
`define TWIM_OFS_STAT 12'h044
`define TWIM_OFS_CMD 12'h04c
`define TWIM_OFS_ACK 12'h050
`define TWIM_BIT_RECV 0
`define TWIM_BIT_SEND 1
`define TWIM_BIT_START 2
`define TWIM_BIT_STOP 3
`define TWIM_MODE_TWI 3'h3
`define TWIM_REF_HZ 12000000
`define TWIM_CLK_HZ 40000000
// reference ticks per system cycle, fixed point x256, kept in int range
`define TWIM_STEP_X256 (((`TWIM_REF_HZ / 1000) * 256) / (`TWIM_CLK_HZ / 1000))
`endif

/* twim_pkg.sv */
// types shared by the twi master
package twim_pkg;
  // serial line group: clock and data output enables
  typedef struct packed {
    logic scl_oe;
    logic sda_oe;
  } twim_pins_t;
  typedef enum logic [3:0] {
    ST_IDLE, ST_START, ST_BIT, ST_ACK, ST_STOP
  } twim_state_t;
endpackage

/* twim_slave_model.sv */
// behavioural two-wire slave for the master bench
`timescale 1ns/100ps
module twim_slave_model (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // resolved wire levels
  input wire logic scl,
  input wire logic sda,
  // behaviour set by the bench
  input wire logic rd,
  input wire logic nack,
  input wire logic stretch,
  input wire logic [7:0] tx_byte,
  // open drain pulls and captured bits
  output logic scl_low,
  output logic sda_low,
  output logic [8:0] cap
);
  logic scl_q, sda_q; // previous wire levels
  logic [3:0] idx_r; // bit slot, 15 right after a start
  logic [7:0] hold_r; // stretch countdown
  // edge detection, bit counting and stretching
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      scl_q <= 1'b1;
      sda_q <= 1'b1;
      idx_r <= 4'hf;
      hold_r <= 8'h0;
      cap <= 9'h0;
    end else begin
      scl_q <= scl;
      sda_q <= sda;
      if (scl && sda_q && !sda) begin
        // start seen: the falling clock after it opens bit 0
        idx_r <= 4'hf;
      end else if (scl_q && !scl) begin
        idx_r <= (idx_r == 4'h8) ? 4'h0 : idx_r + 4'h1;
        if (stretch) hold_r <= 8'h14; // clock held low after each fall
      end else if (hold_r != 8'h0) begin
        hold_r <= hold_r - 8'h1;
      end
      // sample data on each rising clock, ninth bit last
      if (!scl_q && scl) cap <= {cap[7:0], sda};
    end
  end
  // released lines float high through the pull-up
  assign scl_low = hold_r != 8'h0;
  assign sda_low = rd ? (idx_r < 4'h8 && !tx_byte[3'h7 - idx_r[2:0]])
                      : (idx_r == 4'h8 && !nack);
endmodule

/* twi_master_segment_ctrl_tb.sv */
// self-checking bench for the twi master
`timescale 1ns/100ps
`include "twim_map.svh"
module twi_master_segment_ctrl_tb;
  logic clk = 0, rst = 1, psel = 0, penable = 0, pwrite = 0;
  logic [11:0] paddr = 0;
  logic [31:0] pwdata = 0, prdata, q;
  logic pready, pslverr, scl_o, sda_o, scl_oe, sda_oe;
  logic rd = 0, nack = 0, stretch = 0, scl_low, sda_low;
  logic [7:0] tx_byte = 0;
  logic [8:0] cap;
  logic scl, sda; // wired-and with pull-up
  logic [7:0] tb_b [3] = '{8'hf2, 8'h34, 8'ha5};
  logic nk [3] = '{1'b0, 1'b0, 1'b1};
  int err_total = 0, num_checks = 0;
  assign scl = !(scl_oe | scl_low);
  assign sda = !(sda_oe | sda_low);
  always #12.5 clk = ~clk;
  twim_master u_twim_master (.clk(clk), .rst(rst), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .scl_i(scl),
    .sda_i(sda), .scl_o(scl_o), .sda_o(sda_o), .scl_oe(scl_oe),
    .sda_oe(sda_oe));
  twim_slave_model u_twim_slave_model (.clk(clk), .rst(rst), .scl(scl),
    .sda(sda), .rd(rd), .nack(nack), .stretch(stretch), .tx_byte(tx_byte),
    .scl_low(scl_low), .sda_low(sda_low), .cap(cap));
  // one apb transfer: setup, then access until pready
  task automatic apb(input logic w, input logic [11:0] a,
                     input logic [31:0] d, output logic [31:0] r);
    int n;
    @(posedge clk);
    psel <= 1; penable <= 0; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge clk);
    penable <= 1;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 100);
    r = prdata;
    psel <= 0;
    penable <= 0;
  endtask
  // compare and count
  task automatic chk(input string nm, input logic [31:0] e, g);
    num_checks++;
    if (g !== e) begin
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
      err_total++;
    end
  endtask
  // issue a segment, wait for its bit to clear, then check status
  task automatic seg(input logic [3:0] c, input logic [31:0] st);
    int n;
    n = 0;
    if (c != 4'h0) apb(1, `TWIM_OFS_CMD, {28'h0, c}, q);
    do begin
      apb(0, `TWIM_OFS_CMD, 32'h0, q);
      n++;
    end while (q !== 32'h0 && n < 3000);
    chk("command bits", 32'h0, q);
    apb(0, `TWIM_OFS_STAT, 32'h0, q);
    chk("status", st, q);
  endtask
  // print counts and verdict, then stop
  task test_done;
    $display("checks %0d mismatches %0d", num_checks, err_total);
    if (err_total == 0 && num_checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  // watchdog against a hung handshake
  initial begin
    #2000000;
    err_total++;
    test_done;
  end
  // main sequence
  initial begin
    repeat (20) @(posedge clk);
    rst <= 0;
    apb(0, `TWIM_OFS_STAT, 32'h0, q);
    chk("status reset", 32'h0, q);
    apb(0, 12'h100, 32'h0, q);
    chk("unmapped", 32'h0, q);
    apb(1, `TWIM_OFS_RLIN, 32'h0, q);
    apb(1, `TWIM_OFS_REXP, 32'h0, q);
    // start pending while the function is not selected
    apb(1, `TWIM_OFS_CMD, 32'h4, q);
    repeat (60) @(posedge clk);
    apb(0, `TWIM_OFS_CMD, 32'h0, q);
    chk("held command", 32'h4, q);
    chk("lines idle", 32'h3, {30'h0, scl, sda});
    apb(1, `TWIM_OFS_MODE, 32'h3, q);
    seg(4'h0, 32'h8);
    // ten bit address then a data byte answered with nack
    for (int i = 0; i < 3; i++) begin
      nack <= nk[i];
      apb(1, `TWIM_OFS_DATA, {24'h0, tb_b[i]}, q);
      seg(4'h2, {30'h0, 1'b1, nk[i]});
      chk("slave byte", {tb_b[i], nk[i]}, {23'h0, cap});
    end
    seg(4'h4, 32'h8);
    // seven bit address with the read direction, answered with ack
    nack <= 0;
    apb(1, `TWIM_OFS_DATA, 32'h75, q);
    seg(4'h2, 32'h2);
    chk("read address", {23'h0, 8'h75, 1'b0}, {23'h0, cap});
    // two reads under clock stretching, ack then nack
    stretch <= 1;
    rd <= 1;
    for (int i = 0; i < 2; i++) begin
      tx_byte <= i ? 8'hc3 : 8'h3c;
      apb(1, `TWIM_OFS_ACK, {31'h0, i == 0}, q);
      seg(4'h1, 32'h4);
      chk("ack bit", 32'(i), {31'h0, cap[0]});
      apb(0, `TWIM_OFS_DATA, 32'h0, q);
      chk("rx data", {24'h0, tx_byte}, q);
    end
    rd <= 0;
    seg(4'h8, 32'h8);
    repeat (100) @(posedge clk);
    chk("lines after stop", 32'h3, {30'h0, scl, sda});
    apb(0, `TWIM_OFS_STAT, 32'h0, q);
    chk("status idle", 32'h8, q);
    chk("slave error", 32'h0, {31'h0, pslverr});
    chk("drive levels", 32'h0, {30'h0, scl_o, sda_o});
    test_done;
  end
endmodule
